/* File: src/assc_pkg.sv */
// assc_pkg: types and constants for the axis speed / position switch sequencer.
// assumes one 10 MHz clock domain; all speeds are position units per clock cycle.
package assc_pkg;

  localparam int SPD_W = 16;
  localparam int POS_W = 32;
  localparam int CLK_PERIOD_NS = 100;

  localparam logic [POS_W-1:0] FEED_POS_RST = 32'h0000_0000;
  localparam logic [POS_W-1:0] DEV_RST = 32'h0000_0000;
  localparam logic [SPD_W-1:0] SPEED_RST = 16'h0000;
  localparam logic [SPD_W-1:0] TORQUE_RST = 16'h0000;
  localparam logic [SPD_W-1:0] STEP_RST = 16'h0001;
  localparam logic [SPD_W-1:0] MIN_CREEP = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SPEED = 3'b001,
    ST_POS = 3'b010,
    ST_DECEL = 3'b011,
    ST_HOLD = 3'b100
  } assc_state_t;

  typedef enum logic [1:0] {
    MD_LOOP = 2'b00,
    MD_FREE = 2'b01,
    MD_SWITCH = 2'b10
  } assc_mode_t;

  // one-cycle instruction strobes from the command program
  typedef struct packed {
    logic loop_speed_fwd;
    logic loop_speed_rev;
    logic loopfree_speed_fwd;
    logic loopfree_speed_rev;
    logic switch_mode_fwd;
    logic switch_mode_rev;
    logic switch_mode_restart;
  } assc_instr_t;

  // operands carried by the servo instruction
  typedef struct packed {
    logic [SPD_W-1:0] speed;
    logic [POS_W-1:0] travel;
    logic dwell_set;
    logic ramp_override;
    logic [SPD_W-1:0] acc_step;
    logic [SPD_W-1:0] dec_step;
    logic [SPD_W-1:0] rapid_step;
    logic torque_indirect;
    logic [SPD_W-1:0] torque;
  } assc_prog_t;

  // selected parameter block
  typedef struct packed {
    logic [SPD_W-1:0] acc_step;
    logic [SPD_W-1:0] dec_step;
    logic [SPD_W-1:0] rapid_step;
    logic [SPD_W-1:0] torque;
  } assc_pblock_t;

endpackage : assc_pkg

/* File: src/assc_axis_ctrl.sv */
// assc_axis_ctrl: per-axis speed, loop-free speed and speed/position switch sequencer.
// assumes instruction strobes and control bits come from logic on core_clk_in;
// the external switching input is asynchronous and is synchronised here.
`timescale 1ns/100ps
`default_nettype none

//
// Notes on behaviour
// - loop-free speed: run at commanded speed until stop; forward or reverse start
// - loop-free speed runs with the position loop open
// - loop-free speed holds feed position and deviation at zero
// - indirect torque limit follows its source live during loop-free motion
// - loop-free speed uses the same stop commands and handling as loop speed
// - stop rise decelerates with decel step; rapid stop rise uses rapid step
// - feed position is not zeroed by reset or servo power-on in absolute systems
// - a start carrying a dwell time is refused
// - scope probe of loop-free speed command stays zero
// - switch mode: speed control, then on switching input move the travel value
// - switch forward moves toward higher addresses, reverse toward lower
// - switching input only counts while switch enable bit is set
// - enable set after input already active: no switch, speed control continues
// - switch mode has forward start, reverse start and restart after a stop
// - switch needs start accept, speed phase of switch start, and enable set
// - enable and input both active at start: position only, no speed flag
module assc_axis_ctrl
  import assc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire assc_instr_t instr_in,
  input wire assc_prog_t prog_in,
  input wire assc_pblock_t pblock_in,
  input wire logic axis_stop_cmd_in,
  input wire logic axis_rapid_stop_cmd_in,
  input wire logic switch_enable_bit_in,
  input wire logic switch_change_in,
  input wire logic abs_sys_in,
  input wire logic [POS_W-1:0] abs_pos_in,
  input wire logic [SPD_W-1:0] fb_step_in,
  output logic [SPD_W-1:0] cmd_speed_out,
  output logic cmd_fwd_out,
  output logic pos_loop_en_out,
  output logic [POS_W-1:0] feed_pos_out,
  output logic [POS_W-1:0] deviation_out,
  output logic [SPD_W-1:0] torque_limit_out,
  output logic start_accept_flag_out,
  output logic speed_controlling_flag_out,
  output logic dwell_reject_out,
  output logic [SPD_W:0] scope_probe_out
);

  assc_state_t state_q, state_d;
  assc_mode_t mode_q, mode_d;
  logic dir_q, dir_d;
  logic [SPD_W-1:0] speed_q, speed_d;
  logic [SPD_W-1:0] tgt_q, tgt_d;
  logic [SPD_W-1:0] acc_q, acc_d;
  logic [SPD_W-1:0] dec_q, dec_d;
  logic [SPD_W-1:0] rapid_q, rapid_d;
  logic [POS_W-1:0] rem_q, rem_d;
  logic [POS_W-1:0] feed_q, feed_d;
  logic [POS_W-1:0] dev_q, dev_d;
  logic [SPD_W-1:0] torque_q, torque_d;
  logic torque_ind_q, torque_ind_d;
  logic accept_q, accept_d;
  logic spdctl_q, spdctl_d;
  logic dwell_rej_q, dwell_rej_d;
  logic [SPD_W:0] probe_q, probe_d;
  logic loop_en_q, loop_en_d;
  logic init_q, init_d;
  logic switched_q, switched_d;
  logic stop_prev_q, rstop_prev_q;
  logic chg_s1_q, chg_s2_q, chg_s3_q, chg_lvl_q, chg_lvl_d;

  logic stop_rise, rstop_rise, chg_rise, moving, any_start, new_start, brake;
  logic [SPD_W:0] sum_spd;
  logic [SPD_W:0] vel;
  logic [2*SPD_W-1:0] speed_sq;
  logic [POS_W+SPD_W:0] brake_dist;
  logic [SPD_W-1:0] acc_src, dec_src, rapid_src, step;

  assign acc_src = prog_in.ramp_override ? prog_in.acc_step : pblock_in.acc_step;
  assign dec_src = prog_in.ramp_override ? prog_in.dec_step : pblock_in.dec_step;
  assign rapid_src = prog_in.ramp_override ? prog_in.rapid_step : pblock_in.rapid_step;

  always_comb
  begin
    stop_rise = axis_stop_cmd_in & ~stop_prev_q;
    rstop_rise = axis_rapid_stop_cmd_in & ~rstop_prev_q;
    // a change counts once the last two stages agree; edges only count with enable set
    chg_lvl_d = (chg_s2_q == chg_s3_q) ? chg_s3_q : chg_lvl_q;
    chg_rise = chg_lvl_d & ~chg_lvl_q & switch_enable_bit_in;
    moving = (state_q == ST_SPEED) || (state_q == ST_POS) || (state_q == ST_DECEL);
    any_start = instr_in.loop_speed_fwd | instr_in.loop_speed_rev
              | instr_in.loopfree_speed_fwd | instr_in.loopfree_speed_rev
              | instr_in.switch_mode_fwd | instr_in.switch_mode_rev;
    new_start = any_start && ((state_q == ST_IDLE) || (state_q == ST_HOLD));
    vel = dir_q ? {1'b0, speed_q} : {(SPD_W+1){1'b0}} - {1'b0, speed_q};
    // the last move of a position phase covers only what is left, so travel lands exactly
    step = (state_q == ST_POS && {{(POS_W-SPD_W){1'b0}}, speed_q} >= rem_q)
         ? rem_q[SPD_W-1:0] : speed_q;
    speed_sq = speed_q * speed_q;
    brake_dist = {rem_q, 1'b0} * dec_q;
    brake = {{(POS_W-SPD_W+1){1'b0}}, speed_sq} >= brake_dist;
    sum_spd = {1'b0, speed_q} + {1'b0, acc_q};
  end

  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    dir_d = dir_q;
    speed_d = speed_q;
    tgt_d = tgt_q;
    acc_d = acc_q;
    dec_d = dec_q;
    rapid_d = rapid_q;
    rem_d = rem_q;
    feed_d = feed_q;
    dev_d = dev_q;
    torque_d = torque_q;
    torque_ind_d = torque_ind_q;
    accept_d = accept_q;
    spdctl_d = spdctl_q;
    dwell_rej_d = dwell_rej_q;
    loop_en_d = loop_en_q;
    init_d = 1'b0;
    switched_d = switched_q;
    // feed position comes back from the absolute encoder after reset in absolute systems, otherwise it reloads zero
    if (init_q)
    begin
      feed_d = abs_sys_in ? abs_pos_in : FEED_POS_RST;
    end
    if (new_start)
    begin
      if (prog_in.dwell_set)
      begin
        dwell_rej_d = 1'b1;
      end
      else
      begin
        dwell_rej_d = 1'b0;
        dir_d = instr_in.loop_speed_fwd | instr_in.loopfree_speed_fwd
              | instr_in.switch_mode_fwd;
        mode_d = (instr_in.loopfree_speed_fwd | instr_in.loopfree_speed_rev) ? MD_FREE :
                 (instr_in.switch_mode_fwd | instr_in.switch_mode_rev) ? MD_SWITCH : MD_LOOP;
        tgt_d = prog_in.speed;
        acc_d = acc_src;
        dec_d = dec_src;
        rapid_d = rapid_src;
        torque_d = prog_in.torque_indirect ? prog_in.torque : pblock_in.torque;
        torque_ind_d = prog_in.torque_indirect;
        accept_d = 1'b1;
        switched_d = 1'b0;
        rem_d = prog_in.travel;
        loop_en_d = !(instr_in.loopfree_speed_fwd | instr_in.loopfree_speed_rev);
        if (instr_in.loopfree_speed_fwd | instr_in.loopfree_speed_rev)
        begin
          feed_d = FEED_POS_RST;
          dev_d = DEV_RST;
        end
        if ((instr_in.switch_mode_fwd | instr_in.switch_mode_rev)
            && switch_enable_bit_in && chg_lvl_q)
        begin
          state_d = ST_POS;
          spdctl_d = 1'b0;
          switched_d = 1'b1;
        end
        else
        begin
          state_d = ST_SPEED;
          spdctl_d = 1'b1;
        end
      end
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          speed_d = SPEED_RST;
        end
        ST_HOLD:
        begin
          if (instr_in.switch_mode_restart)
          begin
            state_d = switched_q ? ST_POS : ST_SPEED;
            spdctl_d = !switched_q;
            accept_d = 1'b1;
          end
        end
        ST_SPEED, ST_POS:
        begin
          // both stop kinds apply identically in every mode; rapid wins if both rise
          if (rstop_rise)
          begin
            state_d = ST_DECEL;
            dec_d = rapid_q;
          end
          else if (stop_rise)
          begin
            state_d = ST_DECEL;
            dec_d = dec_src;
          end
          else if (state_q == ST_SPEED)
          begin
            speed_d = (sum_spd > {1'b0, tgt_q}) ? tgt_q : sum_spd[SPD_W-1:0];
            if (speed_q > tgt_q)
            begin
              speed_d = (speed_q - tgt_q > dec_q) ? speed_q - dec_q : tgt_q;
            end
            if ((mode_q == MD_SWITCH) && chg_rise && accept_q && spdctl_q)
            begin
              state_d = ST_POS;
              spdctl_d = 1'b0;
              switched_d = 1'b1;
            end
          end
          else if ({{(POS_W-SPD_W){1'b0}}, speed_q} >= rem_q && speed_q != SPEED_RST)
          begin
            speed_d = SPEED_RST;
            rem_d = FEED_POS_RST;
            state_d = ST_IDLE;
            accept_d = 1'b0;
          end
          else
          begin
            rem_d = rem_q - {{(POS_W-SPD_W){1'b0}}, speed_q};
            if (brake)
            begin
              speed_d = (speed_q > dec_q + MIN_CREEP) ? speed_q - dec_q : MIN_CREEP;
            end
            else
            begin
              speed_d = (sum_spd > {1'b0, tgt_q}) ? tgt_q : sum_spd[SPD_W-1:0];
            end
            if (speed_q == SPEED_RST && speed_d == SPEED_RST)
            begin
              speed_d = MIN_CREEP;
            end
          end
        end
        ST_DECEL:
        begin
          speed_d = (speed_q > dec_q) ? speed_q - dec_q : SPEED_RST;
          if (speed_q <= dec_q)
          begin
            state_d = (mode_q == MD_SWITCH) ? ST_HOLD : ST_IDLE;
            accept_d = 1'b0;
            spdctl_d = 1'b0;
          end
        end
        default:
        begin
          state_d = ST_IDLE;
        end
      endcase
      // pulses counted in the position loop modes only
      if (moving && mode_q != MD_FREE)
      begin
        feed_d = dir_q ? feed_q + {{(POS_W-SPD_W){1'b0}}, step}
                       : feed_q - {{(POS_W-SPD_W){1'b0}}, step};
        dev_d = dev_q + {{(POS_W-SPD_W){vel[SPD_W]}}, vel[SPD_W-1:0]}
              - {{(POS_W-SPD_W){fb_step_in[SPD_W-1]}}, fb_step_in};
      end
      if (moving && mode_q == MD_FREE && torque_ind_q)
      begin
        torque_d = prog_in.torque;
      end
    end
    // the scope never sees the loop-free speed command
    probe_d = (moving && mode_q == MD_FREE) ? '0 : vel;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_q <= ST_IDLE;
      mode_q <= MD_LOOP;
      dir_q <= 1'b1;
      speed_q <= SPEED_RST;
      tgt_q <= SPEED_RST;
      acc_q <= STEP_RST;
      dec_q <= STEP_RST;
      rapid_q <= STEP_RST;
      rem_q <= FEED_POS_RST;
      feed_q <= FEED_POS_RST;
      dev_q <= DEV_RST;
      torque_q <= TORQUE_RST;
      torque_ind_q <= 1'b0;
      accept_q <= 1'b0;
      spdctl_q <= 1'b0;
      dwell_rej_q <= 1'b0;
      probe_q <= '0;
      loop_en_q <= 1'b1;
      init_q <= 1'b1;
      switched_q <= 1'b0;
      stop_prev_q <= 1'b0;
      rstop_prev_q <= 1'b0;
      chg_s1_q <= 1'b0;
      chg_s2_q <= 1'b0;
      chg_s3_q <= 1'b0;
      chg_lvl_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      dir_q <= dir_d;
      speed_q <= speed_d;
      tgt_q <= tgt_d;
      acc_q <= acc_d;
      dec_q <= dec_d;
      rapid_q <= rapid_d;
      rem_q <= rem_d;
      feed_q <= feed_d;
      dev_q <= dev_d;
      torque_q <= torque_d;
      torque_ind_q <= torque_ind_d;
      accept_q <= accept_d;
      spdctl_q <= spdctl_d;
      dwell_rej_q <= dwell_rej_d;
      probe_q <= probe_d;
      loop_en_q <= loop_en_d;
      init_q <= init_d;
      switched_q <= switched_d;
      stop_prev_q <= axis_stop_cmd_in;
      rstop_prev_q <= axis_rapid_stop_cmd_in;
      chg_s1_q <= switch_change_in;
      chg_s2_q <= chg_s1_q;
      chg_s3_q <= chg_s2_q;
      chg_lvl_q <= chg_lvl_d;
    end
  end

  assign cmd_speed_out = speed_q;
  assign cmd_fwd_out = dir_q;
  assign pos_loop_en_out = loop_en_q;
  assign feed_pos_out = feed_q;
  assign deviation_out = dev_q;
  assign torque_limit_out = torque_q;
  assign start_accept_flag_out = accept_q;
  assign speed_controlling_flag_out = spdctl_q;
  assign dwell_reject_out = dwell_rej_q;
  assign scope_probe_out = probe_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_free_run;
    moving && mode_q == MD_FREE;
  endsequence

  sequence s_switch_taken;
    state_q == ST_SPEED && mode_q == MD_SWITCH && chg_rise && accept_q && spdctl_q
      && !stop_rise && !rstop_rise && !new_start;
  endsequence

  a_free_pos_zero: assert property (s_free_run |-> feed_q == '0 && dev_q == '0)
    else $error("feed or deviation moved in loop-free mode");
  a_free_loop_open: assert property (s_free_run |-> !pos_loop_en_out)
    else $error("position loop closed in loop-free mode");
  a_free_probe_zero: assert property (s_free_run |=> probe_q == '0)
    else $error("scope probe non-zero in loop-free mode");
  a_torque_live: assert property (s_free_run ##0 torque_ind_q && !new_start
    |=> torque_q == $past(prog_in.torque))
    else $error("indirect torque limit not followed");
  a_rapid_stop_step: assert property ((state_q == ST_SPEED || state_q == ST_POS)
    && rstop_rise && !new_start |=> state_q == ST_DECEL && dec_q == $past(rapid_q))
    else $error("rapid stop did not use rapid step");
  a_stop_decel: assert property ((state_q == ST_SPEED || state_q == ST_POS)
    && stop_rise && !rstop_rise && !new_start |=> state_q == ST_DECEL)
    else $error("stop command did not start deceleration");
  a_switch_taken: assert property (s_switch_taken |=> state_q == ST_POS ##1 !spdctl_q)
    else $error("switching input not taken");
  a_no_enable_ignore: assert property (state_q == ST_SPEED && !switch_enable_bit_in
    && !new_start |=> state_q != ST_POS)
    else $error("switched while enable clear");
  a_direct_position: assert property (new_start && !prog_in.dwell_set
    && (instr_in.switch_mode_fwd || instr_in.switch_mode_rev) && switch_enable_bit_in
    && chg_lvl_q |=> state_q == ST_POS && !speed_controlling_flag_out)
    else $error("direct position start raised speed flag");
  a_dwell_refused: assert property (new_start && prog_in.dwell_set
    |=> dwell_reject_out && !($changed(state_q)))
    else $error("start with dwell time not refused");
  a_abs_restore: assert property (init_q && abs_sys_in |=> feed_q == $past(abs_pos_in))
    else $error("absolute position not restored");

endmodule : assc_axis_ctrl

`default_nettype wire

/* File: sim/assc_servo_model.sv */
// assc_servo_model: servo amplifier stand-in that returns feedback pulses.
// assumes the command speed and direction registers of the sequencer.
`timescale 1ns/100ps
`default_nettype none
module assc_servo_model
  import assc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic slow_in,
  input wire logic [SPD_W-1:0] cmd_speed_in,
  input wire logic cmd_fwd_in,
  output logic [SPD_W-1:0] fb_step_out
);
  // a slow amplifier follows at half rate, so a real deviation builds up
  logic [SPD_W-1:0] mag;
  always_comb mag = slow_in ? (cmd_speed_in >> 1) : cmd_speed_in;
  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in)
      fb_step_out <= 16'h0000;
    else
      fb_step_out <= cmd_fwd_in ? mag : (16'h0000 - mag);
endmodule : assc_servo_model
`default_nettype wire

/* File: sim/assc_axis_ctrl_tb.sv */
// assc_axis_ctrl_tb: self-checking bench for the axis sequencer.
// assumes the servo model on the far side; inputs change on falling edges.
`timescale 1ns/100ps
`default_nettype none
module assc_axis_ctrl_tb
  import assc_pkg::*;
;
  typedef struct packed {
    logic [2:0] ib;
    logic rap;
    logic ovr;
    logic efwd;
    logic eloop;
  } assc_row_t;
  // strobe bit, rapid stop, step override, expected direction, expected loop
  localparam assc_row_t ROWS [6] = '{
    '{3'h6, 1'h0, 1'h0, 1'h1, 1'h1}, '{3'h5, 1'h1, 1'h1, 1'h0, 1'h1},
    '{3'h4, 1'h1, 1'h0, 1'h1, 1'h0}, '{3'h3, 1'h0, 1'h1, 1'h0, 1'h0},
    '{3'h2, 1'h0, 1'h0, 1'h1, 1'h1}, '{3'h1, 1'h1, 1'h1, 1'h0, 1'h1}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  assc_instr_t instr;
  assc_prog_t prog;
  assc_pblock_t pb;
  logic stp, rstp, en, chg, abs_sys, slow, fwd, loop_en, acc, sflag, dwr;
  logic [POS_W-1:0] abs_pos, feed, dev;
  logic [SPD_W-1:0] fb, spd, tq;
  logic [SPD_W:0] scope;
  int miscompares = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  assc_axis_ctrl dut (.core_clk_in(clk), .nrst_in(nrst), .instr_in(instr), .prog_in(prog),
    .pblock_in(pb), .axis_stop_cmd_in(stp), .axis_rapid_stop_cmd_in(rstp),
    .switch_enable_bit_in(en), .switch_change_in(chg), .abs_sys_in(abs_sys),
    .abs_pos_in(abs_pos), .fb_step_in(fb), .cmd_speed_out(spd), .cmd_fwd_out(fwd),
    .pos_loop_en_out(loop_en), .feed_pos_out(feed), .deviation_out(dev),
    .torque_limit_out(tq), .start_accept_flag_out(acc),
    .speed_controlling_flag_out(sflag), .dwell_reject_out(dwr), .scope_probe_out(scope));
  assc_servo_model servo (.core_clk_in(clk), .nrst_in(nrst), .slow_in(slow),
    .cmd_speed_in(spd), .cmd_fwd_in(fwd), .fb_step_out(fb));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic sig(input int s);
    return s == 0 ? acc : (s == 1 ? sflag : dwr);
  endfunction : sig
  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(s) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (sig(s) !== v)
    begin
      miscompares++;
      $display("CHECK FAILED wait %0d expected %b seen %b", s, v, sig(s));
      end_of_test();
    end
  endtask : wait_for
  // every intermediate speed must differ from the previous by exactly one step
  task automatic ramp(input logic [SPD_W-1:0] tgt, input logic [SPD_W-1:0] st);
    logic [SPD_W-1:0] p;
    int n;
    p = spd;
    n = 0;
    while (spd !== tgt && n < 80)
    begin
      @(negedge clk);
      n++;
      if (spd !== p && spd !== tgt)
        chk("ramp step", 32'(st), 32'((spd > p) ? spd - p : p - spd));
      p = spd;
    end
    chk("ramp end", 32'(tgt), 32'(spd));
    if (spd !== tgt)
      end_of_test();
  endtask : ramp
  task automatic pulse(input int b);
    instr[b] = 1'b1;
    @(negedge clk);
    instr = '0;
  endtask : pulse
  initial
  begin
    assc_row_t r;
    logic [POS_W-1:0] f0;
    logic seen;
    int n;
    instr = '0;
    prog = '0;
    prog.speed = 16'h0028;
    prog.travel = 32'h0000_0200;
    prog.acc_step = 16'h0008;
    prog.dec_step = 16'h0008;
    prog.rapid_step = 16'h0014;
    prog.torque = 16'h0011;
    pb = '{16'h0004, 16'h0005, 16'h000a, 16'h0033};
    {stp, rstp, en, chg, slow} = 5'h00;
    abs_sys = 1'b1;
    abs_pos = 32'h1234_5678;
    repeat (8) @(negedge clk);
    chk("reset fwd", 32'h1, 32'(fwd));
    chk("reset loop", 32'h1, 32'(loop_en));
    chk("reset accept", 32'h0, 32'(acc));
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    chk("abs feed", abs_pos, feed);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      r = ROWS[i];
      prog.ramp_override = r.ovr;
      slow = r.ib[0];
      f0 = feed;
      pulse(r.ib);
      wait_for(0, 1'b1, 4);
      chk("direction", 32'(r.efwd), 32'(fwd));
      chk("loop closed", 32'(r.eloop), 32'(loop_en));
      ramp(prog.speed, r.ovr ? prog.acc_step : pb.acc_step);
      if (!r.eloop)
      begin
        chk("free feed", 32'h0, feed);
        chk("free dev", 32'h0, dev);
        chk("free scope", 32'h0, 32'(scope));
      end
      else
        chk("feed dir", 32'(r.efwd), 32'($signed(feed - f0) > 0));
      if (r.ib < 3)
        chk("speed flag", 32'h1, 32'(sflag));
      if (r.rap)
        rstp = 1'b1;
      else
        stp = 1'b1;
      if (r.rap)
        ramp(16'h0000, r.ovr ? prog.rapid_step : pb.rapid_step);
      else
        ramp(16'h0000, r.ovr ? prog.dec_step : pb.dec_step);
      wait_for(0, 1'b0, 4);
      {stp, rstp} = 2'h0;
      $display("test row %0d done", i);
    end
    prog.dwell_set = 1'b1;
    pulse(4);
    wait_for(2, 1'b1, 4);
    chk("dwell accept", 32'h0, 32'(acc));
    prog.dwell_set = 1'b0;
    prog.torque_indirect = 1'b1;
    pulse(4);
    wait_for(0, 1'b1, 4);
    chk("dwell cleared", 32'h0, 32'(dwr));
    repeat (2) @(negedge clk);
    chk("torque", 32'h0000_0011, 32'(tq));
    prog.torque = 16'h0022;
    repeat (2) @(negedge clk);
    chk("torque live", 32'h0000_0022, 32'(tq));
    stp = 1'b1;
    wait_for(0, 1'b0, 40);
    stp = 1'b0;
    prog.torque_indirect = 1'b0;
    $display("test dwell torque done");
    pulse(2);
    wait_for(1, 1'b1, 4);
    chg = 1'b1;
    repeat (8) @(negedge clk);
    chk("ignored change", 32'h1, 32'(sflag));
    en = 1'b1;
    repeat (8) @(negedge clk);
    chk("late enable", 32'h3, {30'h0, acc, sflag});
    stp = 1'b1;
    wait_for(0, 1'b0, 40);
    {stp, chg, en} = 3'h0;
    pulse(0);
    wait_for(0, 1'b1, 4);
    stp = 1'b1;
    wait_for(0, 1'b0, 40);
    stp = 1'b0;
    // let the dropped switching input clear the synchroniser before the next start
    repeat (4) @(negedge clk);
    $display("test enable restart done");
    en = 1'b1;
    pulse(2);
    ramp(prog.speed, prog.ramp_override ? prog.acc_step : pb.acc_step);
    chg = 1'b1;
    wait_for(1, 1'b0, 10);
    f0 = feed;
    wait_for(0, 1'b0, 100);
    n = $signed(feed - f0 - prog.travel);
    // the switch point is only known to one cycle of motion
    chk("switch travel", 32'h1, 32'(n >= -40 && n <= 40));
    f0 = feed;
    pulse(1);
    wait_for(0, 1'b1, 4);
    seen = 1'b0;
    n = 0;
    while (acc === 1'b1 && n < 200)
    begin
      @(negedge clk);
      seen = seen | sflag;
      n++;
    end
    chk("no speed phase", 32'h0, 32'({acc, seen}));
    if (n >= 200)
      end_of_test();
    chk("rev travel", prog.travel, f0 - feed);
    {chg, en} = 2'h0;
    $display("test switch done");
    nrst = 1'b0;
    abs_pos = 32'h0000_0abc;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    chk("abs feed again", abs_pos, feed);
    $display("test second reset done");
    end_of_test();
  end
endmodule : assc_axis_ctrl_tb
`default_nettype wire
